/* File: rtl/display_host_interface_frontend.sv */
// How it works
// - straps 000 give 8-bit parallel port
// - straps 010 give 16-bit parallel port
// - straps 001 give 9-bit parallel port
// - straps 011 give full 18-bit port
// - straps 101 give 3-wire 9-bit serial
// - straps 110 give 4-wire 8-bit serial
// - select high means data, low command
// - select pin becomes serial clock
// - write pin gives 4-wire serial command/parameter flag
// - read strobe makes device drive bus
// - serial bit taken on clock rising edge
// - serial reads leave on separate output
// - chip select gates; steady low selects
// - pixels framed by syncs and enable
// - shared bus, unused lines ignored
// - frame is 240 by 320, 16/18 bpp
`timescale 1ns/1ps

// ====================================================================
// Pixel FIFO with gray-coded pointer crossing
module pixel_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 16
) (
  input  wire logic         i_wclk,   // Write clock
  input  wire logic         i_wrst,   // Write reset
  input  wire logic         i_wvalid, // Write valid
  input  wire logic [W-1:0] i_wdata,  // Write data
  output wire logic         o_wready, // Not full
  input  wire logic         i_rclk,   // Read clock
  input  wire logic         i_rrst,   // Read reset
  output wire logic         o_rvalid, // Not empty
  output wire logic [W-1:0] o_rdata,  // Head word
  input  wire logic         i_rready  // Read accept
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] P_ONE = {{AW{1'b0}}, 1'b1};
  localparam logic [AW:0] P_ZERO = '0;

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0]  rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
  wire  [AW:0]  wbin_next  = wbin_reg + P_ONE;
  wire  [AW:0]  rbin_next  = rbin_reg + P_ONE;
  wire  [AW:0]  wgray_next = wbin_next ^ (wbin_next >> 1);
  wire  [AW:0]  rgray_next = rbin_next ^ (rbin_next >> 1);
  wire          full       = wgray_reg ==
                 {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
  wire          push       = i_wvalid & ~full;
  wire          pop        = i_rready & o_rvalid;

  assign o_wready = ~full;
  assign o_rvalid = rgray_reg != wg_s2_reg;
  assign o_rdata  = mem[rbin_reg[AW-1:0]];

  always_ff @(posedge i_wclk) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_wclk) begin
    if (i_wrst) begin
      wbin_reg  <= P_ZERO;
      wgray_reg <= P_ZERO;
      rg_s1_reg <= P_ZERO;
      rg_s2_reg <= P_ZERO;
    end else begin
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
      if (push) begin
        wbin_reg  <= wbin_next;
        wgray_reg <= wgray_next;
      end
    end
  end

  always_ff @(posedge i_rclk) begin
    if (i_rrst) begin
      rbin_reg  <= P_ZERO;
      rgray_reg <= P_ZERO;
      wg_s1_reg <= P_ZERO;
      wg_s2_reg <= P_ZERO;
    end else begin
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
      if (pop) begin
        rbin_reg  <= rbin_next;
        rgray_reg <= rgray_next;
      end
    end
  end
endmodule : pixel_fifo

// ====================================================================
// Host interface front end
module display_host_interface_frontend (
  input  wire logic i_mclk,                    // System clock
  input  wire logic i_rst,                     // Device reset
  input  wire logic i_iface_mode_bit2,         // Mode strap 2
  input  wire logic i_iface_mode_bit1,         // Mode strap 1
  input  wire logic i_iface_mode_bit0,         // Mode strap 0
  input  wire logic i_cs_n,                    // Chip select
  input  wire logic i_data_command_select,     // D/C or serial clock
  input  wire logic i_wr_n,                    // Write or cmd/param
  input  wire logic i_rd_n,                    // Read strobe
  input  wire logic i_serial_data_in,          // Serial input
  output wire logic o_serial_data_out,         // Serial output
  input  wire logic [17:0] i_parallel_data_bus, // Bus in
  output wire logic [17:0] o_parallel_data_bus, // Bus out
  output wire logic o_parallel_data_bus_oe_n,  // Low while driving
  input  wire logic i_pixel_clock,             // Pixel link clock
  input  wire logic i_frame_sync,              // Frame sync
  input  wire logic i_line_sync,               // Line sync
  input  wire logic i_data_enable,             // Pixel enable
  output wire logic o_pixel_ready,             // Pixel FIFO room
  input  wire logic i_rgb_enable,              // Accept pixels
  input  wire logic i_depth_18bpp,             // 1: 262k, 0: 65k
  input  wire logic [17:0] i_read_word,        // Word for reads
  output dhif_pkg::host_word_t o_word,         // Received word
  output wire logic o_word_valid,              // Word valid
  input  wire logic i_word_ready,              // Word accepted
  output wire logic [8:0] o_col,               // Pixel column
  output wire logic [8:0] o_row,               // Pixel row
  output dhif_pkg::mode_t o_mode,              // Latched mode
  output wire logic o_mode_unsupported,        // Bad strap code
  output wire logic o_overrun                  // Word lost
);
  import dhif_pkg::*;

  // ==================================================================
  // Pin synchronisers
  localparam int PW = 26;
  logic [PW-1:0] pin_s1_reg, pin_s2_reg;
  logic          sclk_d_reg, wr_d_reg, rd_d_reg, cs_d_reg;
  wire  [PW-1:0] pins = {i_cs_n, i_data_command_select, i_wr_n,
                         i_rd_n, i_serial_data_in, i_iface_mode_bit2,
                         i_iface_mode_bit1, i_iface_mode_bit0,
                         i_parallel_data_bus};
  wire        cs_n_s = pin_s2_reg[25];
  wire        dc_s   = pin_s2_reg[24];
  wire        wr_s   = pin_s2_reg[23];
  wire        rd_s   = pin_s2_reg[22];
  wire        sda_s  = pin_s2_reg[21];
  wire [2:0]  im_s   = pin_s2_reg[20:18];
  wire [17:0] db_s   = pin_s2_reg[17:0];

  always_ff @(posedge i_mclk) begin
    pin_s1_reg <= pins;
    pin_s2_reg <= pin_s1_reg;
    sclk_d_reg <= dc_s;
    wr_d_reg   <= wr_s;
    rd_d_reg   <= rd_s;
    cs_d_reg   <= cs_n_s;
  end

  // ==================================================================
  // Mode straps
  mode_t mode_reg;
  wire mode_t mode_raw =
    (im_s == IM_DBI8)  ? MODE_DBI8  :
    (im_s == IM_DBI9)  ? MODE_DBI9  :
    (im_s == IM_DBI16) ? MODE_DBI16 :
    (im_s == IM_DBI18) ? MODE_DBI18 :
    (im_s == IM_SPI3)  ? MODE_SPI3  :
    (im_s == IM_SPI4)  ? MODE_SPI4  : MODE_BAD;

  // Straps are caught while reset is held and frozen afterwards.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode_reg <= mode_raw;
    end
  end

  wire is_spi3   = mode_reg == MODE_SPI3;
  wire is_spi4   = mode_reg == MODE_SPI4;
  wire serial    = is_spi3 | is_spi4;
  wire parallel  = ~serial & (mode_reg != MODE_BAD);
  wire selected  = ~cs_n_s;
  wire [17:0] bus_mask =
    (mode_reg == MODE_DBI8)  ? MASK8  :
    (mode_reg == MODE_DBI9)  ? MASK9  :
    (mode_reg == MODE_DBI16) ? MASK16 :
    (mode_reg == MODE_DBI18) ? MASK18 : 18'h00000;

  assign o_mode             = mode_reg;
  assign o_mode_unsupported = mode_reg == MODE_BAD;

  // ==================================================================
  // Parallel write and read
  wire wr_rise = wr_s & ~wr_d_reg;
  wire rd_fall = ~rd_s & rd_d_reg;
  wire pw_evt  = parallel & selected & wr_rise & rd_s;
  logic [17:0] bus_out_reg;
  logic        oe_n_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst | ~parallel | ~selected | rd_s) begin
      oe_n_reg <= 1'b1;
    end else if (rd_fall) begin
      oe_n_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus_out_reg <= 18'h00000;
    end else if (rd_fall & parallel & selected) begin
      bus_out_reg <= i_read_word & bus_mask;
    end
  end

  assign o_parallel_data_bus      = bus_out_reg;
  assign o_parallel_data_bus_oe_n = oe_n_reg;

  // ==================================================================
  // Serial receive and transmit
  logic [8:0] sh_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] tx_reg;
  logic       sdo_reg;
  wire        sclk_rise = dc_s & ~sclk_d_reg;
  wire        sclk_fall = ~dc_s & sclk_d_reg;
  wire        cs_fall   = ~cs_n_s & cs_d_reg;
  wire [3:0]  frame_len = is_spi3 ? SPI3_BITS : SPI4_BITS;
  wire [3:0]  cnt_inc   = bit_cnt_reg + CNT_ONE;
  wire        take_bit  = serial & selected & sclk_rise;
  wire        sw_evt    = take_bit & (cnt_inc == frame_len);
  wire [8:0]  sh_next   = {sh_reg[7:0], sda_s};
  wire [3:0]  cnt_next  = (~serial | ~selected) ? CNT_ZERO :
                          sw_evt ? CNT_ZERO :
                          take_bit ? cnt_inc : bit_cnt_reg;
  // First bit of a 9-bit frame, or the write pin, tells data apart.
  wire        sw_dc     = is_spi3 ? sh_next[8] : wr_s;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sh_reg      <= 9'h000;
      bit_cnt_reg <= CNT_ZERO;
    end else begin
      bit_cnt_reg <= cnt_next;
      if (take_bit) begin
        sh_reg <= sh_next;
      end
    end
  end

  // Read data leaves MSB first, changed on falling serial clock.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_reg  <= SH_ZERO;
      sdo_reg <= 1'b0;
    end else if (serial & cs_fall) begin
      tx_reg  <= i_read_word[7:0];
    end else if (serial & selected & sclk_fall) begin
      sdo_reg <= tx_reg[7];
      tx_reg  <= {tx_reg[6:0], 1'b0};
    end
  end

  assign o_serial_data_out = sdo_reg;

  // ==================================================================
  // Pixel link domain
  logic   prst_s1_reg, prst_s2_reg;
  logic   en_s1_reg, en_s2_reg, dp_s1_reg, dp_s2_reg;
  logic   sof_pend_reg, sol_pend_reg;
  wire    prst    = prst_s2_reg;
  wire    p_push  = i_data_enable & en_s2_reg;
  wire    p_ready;
  wire [17:0] p_mask = dp_s2_reg ? MASK18 : MASK16;
  pixel_t p_word;
  assign p_word = '{sof:  sof_pend_reg | i_frame_sync,
                    sol:  sol_pend_reg | i_line_sync,
                    data: i_parallel_data_bus & p_mask};

  always_ff @(posedge i_pixel_clock) begin
    prst_s1_reg <= i_rst;
    prst_s2_reg <= prst_s1_reg;
    en_s1_reg   <= i_rgb_enable;
    en_s2_reg   <= en_s1_reg;
    dp_s1_reg   <= i_depth_18bpp;
    dp_s2_reg   <= dp_s1_reg;
  end

  // A sync seen in the same cycle as an accepted push marks that pixel, not the next one.
  always_ff @(posedge i_pixel_clock) begin
    if (prst) begin
      sof_pend_reg <= 1'b0;
      sol_pend_reg <= 1'b0;
    end else begin
      if (i_frame_sync & ~(p_push & p_ready)) begin
        sof_pend_reg <= 1'b1;
      end else if (p_push & p_ready) begin
        sof_pend_reg <= 1'b0;
      end
      if (i_line_sync & ~(p_push & p_ready)) begin
        sol_pend_reg <= 1'b1;
      end else if (p_push & p_ready) begin
        sol_pend_reg <= 1'b0;
      end
    end
  end

  assign o_pixel_ready = p_ready;

  wire         f_valid;
  wire [19:0]  f_data;
  wire         f_pop;
  pixel_t      f_pix;
  assign f_pix = f_data;

  pixel_fifo #(
    .W     (20),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_wclk   (i_pixel_clock),
    .i_wrst   (prst),
    .i_wvalid (p_push),
    .i_wdata  (p_word),
    .o_wready (p_ready),
    .i_rclk   (i_mclk),
    .i_rrst   (i_rst),
    .o_rvalid (f_valid),
    .o_rdata  (f_data),
    .i_rready (f_pop)
  );

  // ==================================================================
  // Output word stage
  host_word_t word_reg, word_next, cw_word, px_word;
  logic       valid_reg, overrun_reg;
  logic [8:0] col_reg, row_reg;
  wire        out_free = ~valid_reg | i_word_ready;
  wire        cw_evt   = pw_evt | sw_evt;
  wire        cw_load  = cw_evt & out_free;
  wire        pix_load = f_valid & out_free & ~cw_evt;
  wire        last_col = col_reg == (COLS - POS_ONE);
  wire        last_row = row_reg == (ROWS - POS_ONE);
  wire [8:0]  col_next = (f_pix.sof | last_col) ? POS_ZERO :
                         col_reg + POS_ONE;
  wire [8:0]  row_next = f_pix.sof ? POS_ZERO :
                         ~last_col ? row_reg :
                         last_row ? POS_ZERO : row_reg + POS_ONE;
  assign f_pop = pix_load;

  assign cw_word = pw_evt ?
    host_word_t'{is_cmd: dc_s != DC_DATA, is_pixel: 1'b0, sof: 1'b0,
      sol: 1'b0, data: db_s & bus_mask} :
    host_word_t'{is_cmd: sw_dc != DC_DATA, is_pixel: 1'b0, sof: 1'b0,
      sol: 1'b0, data: {10'h000, sh_next[7:0]}};
  assign px_word = '{is_cmd: 1'b0, is_pixel: 1'b1, sof: f_pix.sof,
                     sol: f_pix.sol, data: f_pix.data};
  assign word_next = cw_load ? cw_word : px_word;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      valid_reg <= 1'b0;
      word_reg  <= '0;
    end else begin
      valid_reg <= cw_load | pix_load | (valid_reg & ~i_word_ready);
      if (cw_load | pix_load) begin
        word_reg <= word_next;
      end
    end
  end

  // Counters start on the last position so a stray pixel lands on 0,0.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      col_reg     <= COLS - POS_ONE;
      row_reg     <= ROWS - POS_ONE;
      overrun_reg <= 1'b0;
    end else begin
      if (pix_load) begin
        col_reg <= col_next;
        row_reg <= row_next;
      end
      if (cw_evt & ~out_free) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  assign o_word       = word_reg;
  assign o_word_valid = valid_reg;
  assign o_col        = col_reg;
  assign o_row        = row_reg;
  assign o_overrun    = overrun_reg;

  // ==================================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_mode_frozen: assert property (
    !$past(i_rst) |-> $stable(mode_reg))
    else $error("mode changed outside reset");
  a_dbi8_width: assert property (
    pw_evt && out_free && mode_reg == MODE_DBI8
    |=> o_word.data == ($past(db_s) & MASK8) && o_word_valid)
    else $error("8-bit write not masked");
  a_dbi16_width: assert property (
    pw_evt && out_free && mode_reg == MODE_DBI16
    |=> o_word.data == ($past(db_s) & MASK16))
    else $error("16-bit write not masked");
  a_dbi9_width: assert property (
    pw_evt && out_free && mode_reg == MODE_DBI9
    |=> o_word.data == ($past(db_s) & MASK9))
    else $error("9-bit write not masked");
  a_dbi18_width: assert property (
    pw_evt && out_free && mode_reg == MODE_DBI18
    |=> o_word.data == $past(db_s))
    else $error("18-bit write lost bits");
  a_spi3_frame: assert property (
    sw_evt && is_spi3 |-> bit_cnt_reg == 4'h8)
    else $error("3-wire frame not nine bits");
  a_spi4_frame: assert property (
    sw_evt && is_spi4 && out_free
    |-> bit_cnt_reg == 4'h7 ##1 o_word.is_cmd == !$past(wr_s))
    else $error("4-wire frame wrong");
  a_dc_decode: assert property (
    pw_evt && out_free |=> o_word.is_cmd == !$past(dc_s))
    else $error("data/command decoded wrongly");
  a_sclk_sample: assert property (
    take_bit |=> sh_reg == {$past(sh_reg[7:0]), $past(sda_s)})
    else $error("serial bit not shifted in");
  a_read_drive: assert property (
    rd_fall && parallel && selected && !rd_s
    |=> !o_parallel_data_bus_oe_n && o_parallel_data_bus ==
        ($past(i_read_word) & $past(bus_mask)))
    else $error("read data not driven");
  a_serial_bus_off: assert property (
    serial |-> ##1 o_parallel_data_bus_oe_n)
    else $error("bus driven in serial mode");
  a_cs_gate: assert property (
    !selected |=> bit_cnt_reg == CNT_ZERO [*2])
    else $error("deselected serial counting");
  a_pixel_pos: assert property (
    pix_load && f_pix.sof |=> o_col == POS_ZERO && o_row == POS_ZERO)
    else $error("frame start not at origin");

  c_par_write: cover property (pw_evt && out_free);
  c_ser_word: cover property (sw_evt && is_spi3);
  c_pixel: cover property (pix_load ##1 pix_load);
  c_read: cover property (rd_fall && parallel && selected);
endmodule : display_host_interface_frontend

/* File: rtl/dhif_pkg.sv */
package dhif_pkg;
  localparam int BUS_W = 18;
  localparam int FIFO_DEPTH = 16;
  // Strap codes as read on mode bits 2, 1, 0.
  localparam logic [2:0] IM_DBI8  = 3'h0;
  localparam logic [2:0] IM_DBI9  = 3'h1;
  localparam logic [2:0] IM_DBI16 = 3'h2;
  localparam logic [2:0] IM_DBI18 = 3'h3;
  localparam logic [2:0] IM_SPI3  = 3'h5;
  localparam logic [2:0] IM_SPI4  = 3'h6;
  localparam logic [17:0] MASK8  = 18'h000ff;
  localparam logic [17:0] MASK9  = 18'h001ff;
  localparam logic [17:0] MASK16 = 18'h0ffff;
  localparam logic [17:0] MASK18 = 18'h3ffff;
  localparam logic [3:0] SPI3_BITS = 4'h9;
  localparam logic [3:0] SPI4_BITS = 4'h8;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [8:0] COLS      = 9'h0f0;
  localparam logic [8:0] ROWS      = 9'h140;
  localparam logic [8:0] POS_ONE   = 9'h001;
  localparam logic [8:0] POS_ZERO  = 9'h000;
  localparam logic [7:0] SH_ZERO   = 8'h00;
  localparam logic       DC_DATA   = 1'b1;

  typedef enum logic [2:0] {
    MODE_DBI8, MODE_DBI9, MODE_DBI16, MODE_DBI18,
    MODE_SPI3, MODE_SPI4, MODE_BAD
  } mode_t;

  typedef struct packed {
    logic             sof;
    logic             sol;
    logic [BUS_W-1:0] data;
  } pixel_t;

  typedef struct packed {
    logic             is_cmd;
    logic             is_pixel;
    logic             sof;
    logic             sol;
    logic [BUS_W-1:0] data;
  } host_word_t;
endpackage : dhif_pkg

/* File: bench/host_model.sv */
`timescale 1ns/1ps
// ====================================================================
// Host side of the display port: drives the shared pins.
module host_model (
  input  wire logic        i_mclk, // System clock
  input  wire logic        i_pclk, // Pixel clock
  input  wire logic        i_rdy,  // Pixel room
  input  wire logic        i_sdo,  // Serial read data
  input  wire logic [17:0] i_bus,  // Bus level
  output logic             o_cs_n, // Chip select
  output logic             o_dc,   // D/C or serial clock
  output logic             o_wr_n, // Write or cmd flag
  output logic             o_rd_n, // Read strobe
  output logic             o_sdi,  // Serial data
  output logic [17:0]      o_bus,  // Bus drive
  output logic             o_fs,   // Frame sync
  output logic             o_ls,   // Line sync
  output logic             o_de    // Pixel enable
);
  initial begin
    o_cs_n = 1'b0;
    o_dc = 1'b0;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_sdi = 1'b0;
    o_bus = 18'h00000;
    o_fs = 1'b0;
    o_ls = 1'b0;
    o_de = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : wait_clk

  task automatic sel(input logic v);
    @(posedge i_mclk);
    o_cs_n <= v;
  endtask : sel

  task automatic par_write(input logic dc, input logic [17:0] d);
    @(posedge i_mclk);
    o_dc <= dc;
    o_bus <= d;
    o_wr_n <= 1'b0;
    wait_clk(3);
    o_wr_n <= 1'b1;
    wait_clk(4);
    o_bus <= 18'h00000;
  endtask : par_write

  task automatic par_read(output logic [17:0] d);
    @(posedge i_mclk);
    o_rd_n <= 1'b0;
    wait_clk(6);
    d = i_bus;
    o_rd_n <= 1'b1;
    wait_clk(5);
  endtask : par_read

  // Read data is taken just before each clock rise after the first.
  task automatic spi(input int n, input logic [8:0] b, input logic f,
                     output logic [7:0] rb);
    rb = 8'h00;
    @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_dc <= 1'b0;
    wait_clk(4);
    o_cs_n <= 1'b0;
    wait_clk(4);
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi <= b[i];
      o_wr_n <= f;
      wait_clk(4);
      if (i < n - 1) begin
        rb = {rb[6:0], i_sdo};
      end
      o_dc <= 1'b1;
      wait_clk(4);
      o_dc <= 1'b0;
    end
    wait_clk(4);
    o_wr_n <= 1'b1;
  endtask : spi

  // Bit 1 of sync is the frame sync, bit 0 the line sync.
  task automatic pix(input logic [17:0] d, input logic [1:0] sync,
                     output logic ok);
    @(posedge i_pclk);
    o_de <= 1'b1;
    o_fs <= sync[1];
    o_ls <= sync[0];
    o_bus <= d;
    @(posedge i_pclk);
    ok = i_rdy;
    o_de <= 1'b0;
    o_fs <= 1'b0;
    o_ls <= 1'b0;
  endtask : pix
endmodule : host_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
// ====================================================================
// Self-checking bench for the host front end.
module tb;
  import dhif_pkg::*;
  logic        mclk, pclk, rst, rgb_en, depth18, word_rdy;
  logic [2:0]  straps;
  logic [17:0] rd_word, bus_host, bus_dev, bus_wire;
  logic        cs_n, dc, wr_n, rd_n, sdi, serial_data_out, oe_n, fs, de, pix_rdy;
  logic        wvalid, unsup, ovr, ls;
  logic [8:0]  col, row, wcol, wrow;
  host_word_t  word;
  mode_t       mode;
  int          bad_count;
  int          compares;
  mode_t       em [8] = '{MODE_DBI8, MODE_DBI9, MODE_DBI16, MODE_DBI18,
                          MODE_BAD, MODE_SPI3, MODE_SPI4, MODE_BAD};
  logic [17:0] mk [4] = '{MASK8, MASK9, MASK16, MASK18};

  assign bus_wire = oe_n ? bus_host : bus_dev;

  display_host_interface_frontend display_host_interface_frontend_i (
    .i_mclk(mclk), .i_rst(rst), .i_iface_mode_bit2(straps[2]),
    .i_iface_mode_bit1(straps[1]), .i_iface_mode_bit0(straps[0]),
    .i_cs_n(cs_n), .i_data_command_select(dc), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_serial_data_in(sdi), .o_serial_data_out(serial_data_out),
    .i_parallel_data_bus(bus_wire), .o_parallel_data_bus(bus_dev),
    .o_parallel_data_bus_oe_n(oe_n), .i_pixel_clock(pclk),
    .i_frame_sync(fs), .i_line_sync(ls), .i_data_enable(de),
    .o_pixel_ready(pix_rdy), .i_rgb_enable(rgb_en),
    .i_depth_18bpp(depth18), .i_read_word(rd_word), .o_word(word),
    .o_word_valid(wvalid), .i_word_ready(word_rdy), .o_col(col),
    .o_row(row), .o_mode(mode), .o_mode_unsupported(unsup),
    .o_overrun(ovr));

  host_model host_model_i (
    .i_mclk(mclk), .i_pclk(pclk), .i_rdy(pix_rdy), .i_sdo(serial_data_out),
    .i_bus(bus_wire), .o_cs_n(cs_n), .o_dc(dc), .o_wr_n(wr_n),
    .o_rd_n(rd_n), .o_sdi(sdi), .o_bus(bus_host), .o_fs(fs), .o_de(de),
    .o_ls(ls));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    pclk = 1'b0;
    #7;
    forever #80 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic do_reset(input logic [2:0] c);
    @(posedge mclk);
    rst <= 1'b1;
    straps <= c;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : do_reset

  task automatic get_word(output host_word_t w);
    int n;
    n = 0;
    while (wvalid !== 1'b1 && n < 80) begin
      @(posedge mclk);
      n++;
    end
    w = word;
    wcol = col;
    wrow = row;
    chk("word_valid", 32'h1, {31'h0, wvalid});
    word_rdy <= 1'b1;
    @(posedge mclk);
    word_rdy <= 1'b0;
    @(posedge mclk);
  endtask : get_word

  task automatic test_modes();
    host_word_t  w;
    logic [17:0] d;
    logic [17:0] e;
    for (int c = 0; c < 8; c++) begin
      do_reset(3'(c));
      chk("mode", {29'h0, em[c]}, {29'h0, mode});
      chk("bad", {31'h0, em[c] == MODE_BAD}, {31'h0, unsup});
      e = (c < 4) ? mk[c[1:0]] : 18'h0;
      if (c < 4) begin
        host_model_i.par_write(1'b0, 18'h3ffff);
        get_word(w);
        chk("cmd", {13'h0, 1'b1, e}, {13'h0, w.is_cmd, w.data});
        host_model_i.par_write(1'b1, 18'h2a5c3);
        get_word(w);
        d = 18'h2a5c3 & e;
        chk("dat", {14'h0, d}, {13'h0, w.is_cmd, w.data});
      end else begin
        host_model_i.par_write(1'b0, 18'h3ffff);
        repeat (10) @(posedge mclk);
        chk("no_word", 32'h0, {31'h0, wvalid});
      end
      host_model_i.par_read(d);
      chk("rd", {14'h0, rd_word & e}, {14'h0, d});
      chk("oe_n", 32'h1, {31'h0, oe_n});
    end
  endtask : test_modes

  task automatic test_cs();
    host_word_t w;
    do_reset(IM_DBI16);
    host_model_i.sel(1'b1);
    host_model_i.par_write(1'b1, 18'h01234);
    repeat (10) @(posedge mclk);
    chk("desel", 32'h0, {31'h0, wvalid});
    host_model_i.sel(1'b0);
    host_model_i.par_write(1'b1, 18'h01234);
    get_word(w);
    chk("sel", 32'h1234, {14'h0, w.data});
  endtask : test_cs

  task automatic test_serial();
    host_word_t w;
    logic [7:0] rb;
    do_reset(IM_SPI3);
    rd_word <= 18'h0003c;
    host_model_i.spi(9, 9'h1a5, 1'b1, rb);
    get_word(w);
    chk("s3", 32'h0a5, {13'h0, w.is_cmd, w.data});
    chk("sdo", 32'h3c, {24'h0, rb});
    host_model_i.spi(9, 9'h05a, 1'b1, rb);
    get_word(w);
    chk("s3c", 32'h4005a, {13'h0, w.is_cmd, w.data});
    do_reset(IM_SPI4);
    host_model_i.spi(8, 9'h0c3, 1'b0, rb);
    get_word(w);
    chk("s4c", 32'h400c3, {13'h0, w.is_cmd, w.data});
    host_model_i.spi(8, 9'h03c, 1'b1, rb);
    get_word(w);
    chk("s4d", 32'h3c, {13'h0, w.is_cmd, w.data});
  endtask : test_serial

  task automatic test_pixels();
    host_word_t w;
    logic       ok;
    int         acc;
    do_reset(IM_DBI18);
    rgb_en <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 241; i++) begin
      host_model_i.pix({2'b11, 16'(i)}, {i == 0, i % 240 == 0}, ok);
      get_word(w);
      chk("px", {14'h0, 2'b00, 16'(i)}, {14'h0, w.data});
      chk("pf", {30'h1, i == 0, i % 240 == 0},
          {29'h0, w.is_pixel, w.sof, w.sol});
      chk("pos", (i % 240) * 512 + i / 240, {14'h0, wcol, wrow});
    end
    depth18 <= 1'b1;
    repeat (8) @(posedge mclk);
    acc = 0;
    ok = 1'b1;
    while (ok && acc < 24) begin
      host_model_i.pix(18'h30100 + 18'(acc), {acc == 0, 1'b0}, ok);
      if (ok) begin
        acc++;
      end
    end
    chk("full", 32'h1,
        {31'h0, acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 2});
    host_model_i.par_write(1'b1, 18'h00001);
    chk("overrun", 32'h1, {31'h0, ovr});
    for (int k = 0; k < acc; k++) begin
      get_word(w);
      chk("drain", {14'h0, 18'h30100 + 18'(k)}, {14'h0, w.data});
    end
    repeat (20) @(posedge mclk);
    chk("empty", 32'h0, {31'h0, wvalid});
  endtask : test_pixels

  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst = 1'b1;
    straps = 3'h0;
    rgb_en = 1'b0;
    depth18 = 1'b0;
    word_rdy = 1'b0;
    rd_word = 18'h1b5a7;
    bad_count = 0;
    compares = 0;
    test_modes();
    test_cs();
    test_serial();
    test_pixels();
    tally_and_finish();
  end

  // The whole run needs well under half of this span.
  initial begin
    #2000000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
